// *** design/ctl_port.v ***
`include "ctl_port_regs.vh"

module ctl_port (
  // System
  input  wire       clock,
  input  wire       sys_rst,
  // Clear sources
  input  wire       supply_lockout,
  input  wire       power_down_state,
  // Bus pins
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe_n,
  // Status inputs
  input  wire       charging,
  input  wire [1:0] charger_fault,
  input  wire [1:0] linear_reg_good,
  input  wire [2:0] stepdown_reg_good,
  // Command latch outputs
  output reg        reg1_burst_sel,
  output reg        reg2_burst_sel,
  output reg        reg3_burst_sel,
  output reg  [1:0] regulator_slew,
  output reg        boost_enable,
  output reg  [1:0] ramp_time,
  output reg  [1:0] boost_mode,
  output reg  [1:0] dim_clock_sel,
  output reg        boost_switch_slow,
  output reg  [5:0] led_current_code,
  output reg  [3:0] dim_denominator,
  output reg  [3:0] dim_numerator
);
  localparam ST_IDLE = 6'h01;
  localparam ST_RECV = 6'h02;
  localparam ST_ACK  = 6'h04;
  localparam ST_SEND = 6'h08;
  localparam ST_MACK = 6'h10;
  localparam ST_WAIT = 6'h20;

  wire scl_s;
  wire sda_s;
  reg  scl_d_r;
  reg  sda_d_r;
  reg  [5:0] state_r;
  reg  [7:0] shift_r;
  reg  [3:0] bit_cnt_r;
  reg  [1:0] byte_idx_r;
  reg        is_read_r;
  reg  [1:0] sel_r;
  reg  [7:0] status_r;
  reg  [7:0] status_meta_r;
  reg  [7:0] status_sync_r;
  reg  [7:0] hold_r [0:3];
  reg  [7:0] cmd_r  [0:3];
  integer    i;
  integer    j;

  pin_sync u_scl (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .pin_in       (scl_in),
    .pin_sync_out (scl_s)
  );
  pin_sync u_sda (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .pin_in       (sda_in),
    .pin_sync_out (sda_s)
  );

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire clear_c  = sys_rst | supply_lockout | power_down_state;

  always @(posedge clock) begin
    if (sys_rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // Status levels arrive on their own timing; bits settle independently,
  // so a change right at capture may mix old and new bits
  always @(posedge clock) begin
    if (sys_rst) begin
      status_meta_r <= 8'h00;
      status_sync_r <= 8'h00;
    end else begin
      status_meta_r <= {stepdown_reg_good, linear_reg_good,
                        charger_fault, charging};
      status_sync_r <= status_meta_r;
    end
  end

  // Port state and holding latches
  always @(posedge clock) begin
    if (clear_c) begin
      state_r    <= ST_IDLE;
      shift_r    <= 8'h00;
      bit_cnt_r  <= 4'h0;
      byte_idx_r <= 2'h0;
      is_read_r  <= 1'b0;
      sel_r      <= 2'h0;
      status_r   <= 8'h00;
      sda_out    <= 1'b1;
      sda_oe_n   <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
        hold_r[i] <= `REG_RESET_VALUE;
      end
    end else if (start_c) begin
      // Repeated start also lands here; holding latches keep data
      state_r    <= ST_RECV;
      bit_cnt_r  <= 4'h0;
      byte_idx_r <= 2'h0;
      sda_oe_n   <= 1'b1;
    end else if (stop_c) begin
      state_r  <= ST_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          sda_oe_n <= 1'b1;
        end
        ST_RECV: begin
          if (scl_rise) begin
            shift_r   <= {shift_r[6:0], sda_s};  // MSB first
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            bit_cnt_r <= 4'h0;
            if (byte_idx_r == 2'h0) begin
              if (shift_r[7:1] == `SLAVE_ADDR) begin
                is_read_r <= shift_r[0];
                state_r   <= ST_ACK;
                sda_out   <= 1'b0;
                sda_oe_n  <= 1'b0;
                if (shift_r[0]) begin
                  status_r <= status_sync_r;
                end
              end else begin
                state_r <= ST_WAIT;
              end
            end else if (byte_idx_r == 2'h1) begin
              sel_r    <= shift_r[1:0];
              state_r  <= ST_ACK;
              sda_out  <= 1'b0;
              sda_oe_n <= 1'b0;
            end else if (byte_idx_r == 2'h2) begin
              hold_r[sel_r] <= shift_r;
              state_r       <= ST_ACK;
              sda_out       <= 1'b0;
              sda_oe_n      <= 1'b0;
            end else begin
              // Fourth byte not acknowledged
              state_r <= ST_WAIT;
            end
          end
        end
        ST_ACK: begin
          // Held low until the acknowledge clock falls
          if (scl_fall) begin
            byte_idx_r <= byte_idx_r + 2'h1;
            if (is_read_r) begin
              state_r   <= ST_SEND;
              sda_out   <= status_r[7];
              sda_oe_n  <= 1'b0;
              shift_r   <= {status_r[6:0], 1'b0};
              bit_cnt_r <= 4'h1;
            end else begin
              sda_out  <= 1'b1;
              sda_oe_n <= 1'b1;
              state_r  <= (byte_idx_r == 2'h2) ? ST_WAIT : ST_RECV;
            end
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            if (bit_cnt_r == 4'h8) begin
              sda_out  <= 1'b1;
              sda_oe_n <= 1'b1;
              state_r  <= ST_MACK;
            end else begin
              sda_out   <= shift_r[7];
              shift_r   <= {shift_r[6:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        ST_MACK: begin
          // Master acknowledge ignored either way
          if (scl_fall) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          sda_oe_n <= 1'b1;
        end
        default: begin
          state_r  <= ST_IDLE;
          sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // Command latches update only at stop or on a clear
  always @(posedge clock) begin
    if (clear_c) begin
      for (j = 0; j < 4; j = j + 1) begin
        cmd_r[j] <= `REG_RESET_VALUE;
      end
    end else if (stop_c) begin
      for (j = 0; j < 4; j = j + 1) begin
        cmd_r[j] <= hold_r[j];
      end
    end
  end

  // Two-bit field of a latch byte, upper bit first
  function [1:0] pick2(input [7:0] byte_v, input integer hi_pos, input integer lo_pos);
    pick2 = {byte_v[hi_pos], byte_v[lo_pos]};
  endfunction

  // Field decode registered so outputs come straight from flops
  always @(posedge clock) begin
    if (clear_c) begin
      reg1_burst_sel    <= 1'b0;
      reg2_burst_sel    <= 1'b0;
      reg3_burst_sel    <= 1'b0;
      regulator_slew    <= 2'h0;
      boost_enable      <= 1'b0;
      ramp_time         <= 2'h0;
      boost_mode        <= 2'h0;
      dim_clock_sel     <= 2'h0;
      boost_switch_slow <= 1'b0;
      led_current_code  <= 6'h00;
      dim_denominator   <= 4'h0;
      dim_numerator     <= 4'h0;
    end else begin
      reg1_burst_sel    <= cmd_r[`REG_REGULATOR_CTL][`BURST1_BIT];
      reg2_burst_sel    <= cmd_r[`REG_REGULATOR_CTL][`BURST2_BIT];
      reg3_burst_sel    <= cmd_r[`REG_REGULATOR_CTL][`BURST3_BIT];
      regulator_slew    <= pick2(cmd_r[`REG_REGULATOR_CTL],
                                 `REG_SLEW_MSB_BIT, `REG_SLEW_LSB_BIT);
      boost_enable      <= cmd_r[`REG_LED_CTL][`BOOST_EN_BIT];
      ramp_time         <= pick2(cmd_r[`REG_LED_CTL],
                                 `RAMP_MSB_BIT, `RAMP_LSB_BIT);
      // Code 11 passed through unchanged; master must not write it
      boost_mode        <= pick2(cmd_r[`REG_LED_CTL],
                                 `MODE_MSB_BIT, `MODE_LSB_BIT);
      dim_clock_sel     <= pick2(cmd_r[`REG_LED_CTL],
                                 `DIMCLK_MSB_BIT, `DIMCLK_LSB_BIT);
      boost_switch_slow <= cmd_r[`REG_LED_CTL][`BOOST_SLOW_BIT];
      led_current_code  <= cmd_r[`REG_LED_CODE][`CODE_MSB:0];
      dim_denominator   <= cmd_r[`REG_LED_PWM][`DEN_MSB:0];
      dim_numerator     <= cmd_r[`REG_LED_PWM][`NUM_MSB:`NUM_LSB];
    end
  end
endmodule

// *** design/ctl_port_regs.vh ***
`ifndef CTL_PORT_REGS_VH
`define CTL_PORT_REGS_VH
`define SLAVE_ADDR          7'h09
`define REG_REGULATOR_CTL   2'h0
`define REG_LED_CTL         2'h1
`define REG_LED_CODE        2'h2
`define REG_LED_PWM         2'h3
`define REG_RESET_VALUE     8'h00
`define BURST1_BIT          2
`define BURST2_BIT          3
`define BURST3_BIT          4
`define REG_SLEW_LSB_BIT    5
`define REG_SLEW_MSB_BIT    6
`define BOOST_EN_BIT        0
`define RAMP_MSB_BIT        1
`define RAMP_LSB_BIT        2
`define MODE_LSB_BIT        3
`define MODE_MSB_BIT        4
`define DIMCLK_LSB_BIT      5
`define DIMCLK_MSB_BIT      6
`define BOOST_SLOW_BIT      7
`define CODE_MSB            5
`define DEN_MSB             3
`define NUM_LSB             4
`define NUM_MSB             7
`endif

// *** design/pin_sync.v ***
// Two-stage synchroniser for pins from outside the clock domain
module pin_sync (
  // System
  input  wire clock,
  input  wire sys_rst,
  // Pin and result
  input  wire pin_in,
  output reg  pin_sync_out
);
  reg meta_r;

  always @(posedge clock) begin
    if (sys_rst) begin
      meta_r       <= 1'b1;
      pin_sync_out <= 1'b1;
    end else begin
      meta_r       <= pin_in;
      pin_sync_out <= meta_r;
    end
  end
endmodule

// *** verification/ctl_port_asserts.sv ***
module ctl_port_asserts (
  // System and clear sources
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       supply_lockout,
  input wire logic       power_down_state,
  // Bus pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  // Command latches
  input wire logic       reg1_burst_sel,
  input wire logic       reg2_burst_sel,
  input wire logic       reg3_burst_sel,
  input wire logic [1:0] regulator_slew,
  input wire logic       boost_enable,
  input wire logic [1:0] ramp_time,
  input wire logic [1:0] boost_mode,
  input wire logic [1:0] dim_clock_sel,
  input wire logic       boost_switch_slow,
  input wire logic [5:0] led_current_code,
  input wire logic [3:0] dim_denominator,
  input wire logic [3:0] dim_numerator
);
  timeunit 1ns / 100ps;
  wire        clr = supply_lockout | power_down_state;
  wire [26:0] cmd = {reg1_burst_sel, reg2_burst_sel, reg3_burst_sel, regulator_slew,
                     boost_enable, ramp_time, boost_mode, dim_clock_sel, boost_switch_slow,
                     led_current_code, dim_denominator, dim_numerator};
  logic [7:0] since_stop_r;
  // Raw pins: the design sees the stop about three clocks later
  always @(posedge clock)
    if (sys_rst || (scl_in && $rose(sda_in))) since_stop_r <= 8'h00;
    else if (since_stop_r != 8'hFF) since_stop_r <= since_stop_r + 8'h01;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst || clr);
  sequence held2(logic s); s ##1 s; endsequence
  sequence bus_start; scl_in && $fell(sda_in); endsequence
  clear_zero_a: assert property (disable iff (sys_rst)
    held2(supply_lockout) |-> cmd == 27'h0 && sda_oe_n) else $error("lockout clear missed");
  power_down_zero_a: assert property (disable iff (sys_rst)
    held2(power_down_state) |-> cmd == 27'h0 && sda_oe_n) else $error("power-down clear missed");
  cmd_hold_a: assert property (!$stable(cmd) |-> since_stop_r < 8'h0C)
    else $error("command latches changed away from a stop");
  ack_min_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
    else $error("data line drive too short");
  drive_lo_a: assert property ($fell(sda_oe_n) |-> !scl_in)
    else $error("data line drive began with clock high");
  drive_stable_a: assert property (!sda_oe_n && scl_in |=> $stable({sda_oe_n, sda_out}))
    else $error("data line moved while clock high");
  drive_max_a: assert property ($fell(sda_oe_n) |-> ##[1:130] sda_oe_n)
    else $error("data line not released");
  start_idle_a: assert property (bus_start |-> sda_oe_n [*4])
    else $error("data line driven at start");
endmodule

// *** verification/i2c_master_model.sv ***
module i2c_master_model (
  // Bus
  output logic      scl   = 1'h1,
  output logic      sda_m = 1'h1,
  input  wire logic sda_line
);
  timeunit 1ns / 100ps;
  // Data moves mid-low so scl and sda edges stay over 40 ns apart
  task automatic bit_xfer(input logic b, output logic r);
    #42 sda_m = b;
    #42 scl = 1'h1;
    #20 r = sda_line;
    #21 scl = 1'h0;
  endtask
  task automatic start();
    if (!scl) begin
      #42 sda_m = 1'h1;
      #42 scl = 1'h1;
    end
    #42 sda_m = 1'h0;
    #42 scl = 1'h0;
  endtask
  task automatic stop();
    #42 sda_m = 1'h0;
    #42 scl = 1'h1;
    #42 sda_m = 1'h1;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], r);
    bit_xfer(1'h1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic mack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'h1, r);
      b[i] = r;
    end
    bit_xfer(~mack, r);
  endtask
endmodule

// *** verification/test_ctl_port.sv ***
module test_ctl_port;
  timeunit 1ns / 100ps;
  localparam logic [7:0] MASK [4] = '{8'h7C, 8'hFF, 8'h3F, 8'hFF};
  logic       clock = 1'h0;
  logic       sys_rst = 1'h1;
  logic       supply_lockout = 1'h0;
  logic       power_down_state = 1'h0;
  logic       charging = 1'h0;
  logic [1:0] charger_fault = 2'h0;
  logic [1:0] linear_reg_good = 2'h0;
  logic [2:0] stepdown_reg_good = 3'h0;
  logic       scl_in, sda_m, sda_out, sda_oe_n, reg1_burst_sel, reg2_burst_sel, k;
  logic       reg3_burst_sel, boost_enable, boost_switch_slow, got_ack;
  logic [1:0] regulator_slew, ramp_time, boost_mode, dim_clock_sel;
  logic [5:0] led_current_code;
  logic [3:0] dim_denominator, dim_numerator;
  logic [7:0] hold [4] = '{4{8'h00}};
  logic [7:0] cmd [4] = '{4{8'h00}};
  logic [7:0] exp_q [$], got;
  logic       ack_q [$];
  int         err_total = 0;
  int         checked = 0;
  event       val_ev, ack_ev;
  // Pull-up: a released line reads high
  wire        sda_in = sda_m & (sda_oe_n | sda_out);
  ctl_port dut (.*);
  i2c_master_model m (.scl(scl_in), .sda_m(sda_m), .sda_line(sda_in));
  always #5 clock = ~clock;
  always @(val_ev) cmp_val(exp_q.pop_front(), got);
  always @(ack_ev) cmp_ack(ack_q.pop_front(), got_ack);
  task automatic cmp_val(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch byte expected %h seen %h", e, g);
    end
  endtask
  task automatic cmp_ack(input logic e, input logic g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch ack expected %b seen %b", e, g);
    end
  endtask
  task automatic note_val(input logic [7:0] e, input logic [7:0] g);
    exp_q.push_back(e);
    got = g;
    ->val_ev;
    #1;
  endtask
  task automatic note_ack(input logic e, input logic g);
    ack_q.push_back(e);
    got_ack = g;
    ->ack_ev;
    #1;
  endtask
  function automatic logic [7:0] view(input int i);
    case (i)
      0: view = {1'h0, regulator_slew, reg3_burst_sel, reg2_burst_sel, reg1_burst_sel, 2'h0};
      1: view = {boost_switch_slow, dim_clock_sel, boost_mode, ramp_time[0], ramp_time[1],
                 boost_enable};
      2: view = {2'h0, led_current_code};
      default: view = {dim_numerator, dim_denominator};
    endcase
  endfunction
  task automatic regs();
    for (int i = 0; i < 4; i++) note_val(cmd[i], view(i));
  endtask
  task automatic trip(input logic [7:0] s, input logic [7:0] d, input logic [1:0] c);
    logic [7:0] b [3];
    d[6:5] = c;
    if (s[1:0] == 2'h1) d[4:1] = {c[1] & ~c[0], c[0], c};
    b = '{8'h12, s, d};
    m.start();
    foreach (b[i]) begin
      m.wr_byte(b[i], k);
      note_ack(1'h1, k);
    end
    hold[s[1:0]] = d & MASK[s[1:0]];
  endtask
  task automatic rd(input logic mack);
    logic [7:0] s, v;
    s = 8'($urandom);
    @(negedge clock) {stepdown_reg_good, linear_reg_good, charger_fault, charging} = s;
    m.start();
    m.wr_byte(8'h13, k);
    note_ack(1'h1, k);
    // Status moves after capture; the old byte must come out
    @(negedge clock) {stepdown_reg_good, linear_reg_good, charger_fault, charging} = ~s;
    m.rd_byte(mack, v);
    note_val(s, v);
  endtask
  task automatic print_verdict();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #800us;
    err_total++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hBD30942D));
    repeat (8) @(negedge clock);
    sys_rst = 1'h0;
    repeat (4) @(negedge clock);
    regs();
    for (int j = 0; j < 4; j++) begin
      for (int i = 0; i < 5; i++) trip(8'(i), 8'($urandom), 2'(j));
      m.wr_byte(8'h3C, k);
      note_ack(1'h0, k);
      regs();
      m.stop();
      #100 cmd = hold;
      regs();
      m.start();
      m.wr_byte(8'h22, k);
      note_ack(1'h0, k);
      rd(j[0]);
      if (j[0]) begin
        @(negedge clock) {power_down_state, supply_lockout} = j[1] ? 2'h2 : 2'h1;
        repeat (3) @(negedge clock);
        {power_down_state, supply_lockout} = 2'h0;
        hold = '{4{8'h00}};
        cmd = hold;
        regs();
      end
    end
    print_verdict();
  end
endmodule
bind ctl_port ctl_port_asserts chk (.*);
